// File: common/sqc_pkg.sv
// constants and types for the supply sequencer channel control block
//
// Summary of operation
// - channel with position select low is unused
// - after start, position select low forces enable low
// - switched-off channel stays off until next start
// - off channel leaves sequencing and monitoring
// - fault clears: command low, supplies below down
// - before start, forced channels drive enable high unless an external fault is present
// - forced channel comparator uses sequence-up threshold
// - reset and overvoltage work outside sequencing
// - forcing with command low suppresses internal faults
// - logged faults kept and reported after forcing
// - master first raises reset fault in monitoring
// - pulled-up completion pin marks last device
// - time position ends at sequence threshold
// - straps low/high give 67 percent thresholds
// - enables spaced by one spacing timer period
// - monitor index matches channel index
// - power-good timer expiry gives sequence fault
// - reset released one reset delay after undervoltage
// - overvoltage flag released one reset delay later
// - fault drives every enable low
// - command high starts up, low starts down
// - completion low after eight positions up, high down
`default_nettype none
package sqc_pkg;
  localparam int NCH = 4;
  localparam logic [3:0] POS_UNUSED = 4'h0;
  localparam logic [3:0] POS_FIRST = 4'h1;
  localparam logic [3:0] POS_LAST = 4'h8;
  localparam logic [3:0] POS_FORCE = 4'hf;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VCC = 2'h3;
  localparam logic [6:0] PCT_67 = 7'h43;
  localparam logic [6:0] PCT_100 = 7'h64;
  localparam int CLK_MHZ = 100;
  localparam int SPACING_MS = 29;
  localparam int POWER_GOOD_MS = 400;
  localparam int RESET_DELAY_MS = 190;
  localparam int EMPTY_POS_US = 25;
  localparam logic [31:0] SPACING_CYC = 32'(SPACING_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] POWER_GOOD_CYC = 32'(POWER_GOOD_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] RESET_DELAY_CYC = 32'(RESET_DELAY_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] EMPTY_POS_CYC = 32'(EMPTY_POS_US * CLK_MHZ);
  localparam logic [31:0] ONE = 32'h0000_0001;
  typedef struct packed {
    logic [3:0] pos;
    logic above_uv;
    logic above_seq;
    logic below_down;
    logic above_ov;
  } sqc_chan_in_type;
  typedef struct packed {
    logic seq;
    logic rst;
    logic ext;
  } sqc_fault_type;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_UP_POS = 3'b001,
    S_UP_GAP = 3'b010,
    S_MON = 3'b011,
    S_DN_POS = 3'b100,
    S_DN_GAP = 3'b101,
    S_FAULT = 3'b110
  } sqc_state_type;
endpackage : sqc_pkg
`default_nettype wire

// File: rtl/sqc_channel_control.sv
// supply sequencer channel control and supervision logic
`default_nettype none
module sqc_channel_control #(
  parameter logic [31:0] SPACING_CYCLES = sqc_pkg::SPACING_CYC,
  parameter logic [31:0] POWER_GOOD_CYCLES = sqc_pkg::POWER_GOOD_CYC,
  parameter logic [31:0] RESET_DELAY_CYCLES = sqc_pkg::RESET_DELAY_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire sqc_pkg::sqc_chan_in_type [3:0] chans,
  input wire logic seq_cmd,
  input wire logic [1:0] designation_strap_a,
  input wire logic [1:0] designation_strap_b,
  input wire logic seq_threshold_strap_a,
  input wire logic seq_threshold_strap_b,
  input wire logic fault_line_n,
  output logic fault_line_oe,
  output logic fault_line_o,
  input wire logic done_pin,
  output logic done_pin_oe,
  output logic done_pin_o,
  output logic cas_pin_oe,
  output logic cas_pin_o,
  output logic [3:0] supply_enable,
  output logic [3:0] comparator_output,
  output logic reset_out_n,
  output logic overvoltage_flag_n,
  output logic [6:0] seq_threshold_pct,
  output logic last_status,
  output var sqc_pkg::sqc_fault_type fault_report
);
  // ****************************************
  // channel decode
  // ****************************************
  function automatic logic [3:0] chan_mask(input sqc_pkg::sqc_chan_in_type [3:0] c,
                                           input logic [3:0] p);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < sqc_pkg::NCH; i++) begin
      m[i] = (c[i].pos == p);
    end
    return m;
  endfunction : chan_mask

  sqc_pkg::sqc_state_type state_r, state_nxt;
  logic [3:0] pos_r, pos_nxt, off_r, off_nxt, en_r, en_nxt, cmp_r, cmp_nxt;
  logic [31:0] tmr_r, tmr_nxt, pg_r, pg_nxt;
  logic pg_run_r, pg_run_nxt, done_oe_r, done_oe_nxt, cas_oe_r, cas_oe_nxt;
  sqc_pkg::sqc_fault_type flog_r, flog_nxt, ev, rep_r, rep_nxt;
  logic flt_oe_r, flt_oe_nxt, last_r, last_nxt, cap_r, cap_nxt;
  logic [6:0] thr_r, thr_nxt;
  logic rst_out_r, rst_out_nxt, ov_r, ov_nxt;
  logic [31:0] rcnt_r, rcnt_nxt, ocnt_r, ocnt_nxt;
  logic [3:0] used, forced, act, m, above_uv, above_seq, below_down, above_ov, mon;
  logic seq_act, forcing, ext_fault, clear, fault_any, master_first, rst_ok;

  always_comb begin
    for (int i = 0; i < sqc_pkg::NCH; i++) begin
      above_uv[i] = chans[i].above_uv;
      above_seq[i] = chans[i].above_seq;
      below_down[i] = chans[i].below_down;
      above_ov[i] = chans[i].above_ov;
    end
  end

  assign used = ~chan_mask(chans, sqc_pkg::POS_UNUSED);
  assign forced = chan_mask(chans, sqc_pkg::POS_FORCE);
  assign act = used & ~forced & ~off_r;
  assign seq_act = (state_r != sqc_pkg::S_IDLE);
  assign forcing = !seq_act && (forced != 4'h0);
  assign ext_fault = !fault_line_n && !flt_oe_r;
  assign clear = !seq_cmd && (below_down == 4'hf);
  assign master_first = (designation_strap_a == sqc_pkg::STRAP_GND) &&
                        (designation_strap_b == sqc_pkg::STRAP_GND);
  assign m = chan_mask(chans, pos_r) & act;
  assign mon = (state_r == sqc_pkg::S_MON) ? act : 4'hf;
  assign rst_ok = ((state_r == sqc_pkg::S_MON) || (state_r == sqc_pkg::S_IDLE)) &&
                  ((mon & above_uv) == mon);

  // ****************************************
  // sequencer and fault log
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    pos_nxt = pos_r;
    tmr_nxt = tmr_r;
    pg_nxt = pg_r;
    pg_run_nxt = pg_run_r;
    done_oe_nxt = done_oe_r;
    cas_oe_nxt = cas_oe_r;
    en_nxt = en_r;
    cmp_nxt = 4'h0;
    ev = '0;
    off_nxt = seq_act ? (off_r | ~used) : off_r;
    ev.ext = ext_fault;
    if (pg_run_r) begin
      pg_nxt = pg_r + sqc_pkg::ONE;
      if (((state_r == sqc_pkg::S_UP_POS) || (state_r == sqc_pkg::S_UP_GAP)) &&
          ((act & above_uv) == act)) begin
        pg_run_nxt = 1'b0;
      end else if (((state_r == sqc_pkg::S_DN_POS) || (state_r == sqc_pkg::S_DN_GAP)) &&
                   ((act & below_down) == act)) begin
        pg_run_nxt = 1'b0;
      end else if (pg_r >= POWER_GOOD_CYCLES - sqc_pkg::ONE) begin
        ev.seq = 1'b1;
        pg_run_nxt = 1'b0;
      end
    end
    // a falling reset here is a supervision failure, not a sequencing step
    ev.rst = master_first && (state_r == sqc_pkg::S_MON) && rst_out_r && !rst_ok;
    if (forcing && !seq_cmd) begin
      ev.seq = 1'b0;
      ev.rst = 1'b0;
    end
    // set wins over clear so no event is lost
    flog_nxt = (clear ? sqc_pkg::sqc_fault_type'(3'h0) : flog_r) | ev;
    fault_any = (flog_nxt != 3'h0);
    unique case (state_r)
      sqc_pkg::S_IDLE: begin
        en_nxt = ext_fault ? 4'h0 : forced;
        cmp_nxt = forced & above_seq;
        pg_run_nxt = 1'b0;
        if (seq_cmd && !forcing && !fault_any) begin
          state_nxt = sqc_pkg::S_UP_POS;
          off_nxt = 4'h0;
          en_nxt = 4'h0;
          pos_nxt = sqc_pkg::POS_FIRST;
          tmr_nxt = 32'h0000_0000;
          cas_oe_nxt = 1'b1;
        end
      end
      sqc_pkg::S_UP_POS: begin
        en_nxt = en_r | m;
        tmr_nxt = tmr_r + sqc_pkg::ONE;
        if ((m != 4'h0) && !pg_run_r && (en_r == 4'h0)) begin
          pg_run_nxt = 1'b1;
          pg_nxt = 32'h0000_0000;
        end
        if ((m == 4'h0) ? (tmr_r >= sqc_pkg::EMPTY_POS_CYC - sqc_pkg::ONE)
                        : ((m & above_seq) == m)) begin
          state_nxt = sqc_pkg::S_UP_GAP;
          cas_oe_nxt = 1'b0;
          tmr_nxt = 32'h0000_0000;
        end
      end
      sqc_pkg::S_UP_GAP: begin
        tmr_nxt = tmr_r + sqc_pkg::ONE;
        if (tmr_r >= SPACING_CYCLES - sqc_pkg::ONE) begin
          tmr_nxt = 32'h0000_0000;
          if (pos_r == sqc_pkg::POS_LAST) begin
            state_nxt = sqc_pkg::S_MON;
            done_oe_nxt = 1'b1;
          end else begin
            state_nxt = sqc_pkg::S_UP_POS;
            pos_nxt = pos_r + 4'h1;
            cas_oe_nxt = 1'b1;
          end
        end
      end
      sqc_pkg::S_MON: begin
        cmp_nxt = act & above_uv;
        if (!seq_cmd) begin
          state_nxt = sqc_pkg::S_DN_POS;
          pos_nxt = sqc_pkg::POS_LAST;
          tmr_nxt = 32'h0000_0000;
          cas_oe_nxt = 1'b1;
          pg_run_nxt = 1'b0;
        end
      end
      sqc_pkg::S_DN_POS: begin
        en_nxt = en_r & ~m;
        tmr_nxt = tmr_r + sqc_pkg::ONE;
        if (((en_r & m) != 4'h0) && !pg_run_r && ((en_r & act) == act)) begin
          pg_run_nxt = 1'b1;
          pg_nxt = 32'h0000_0000;
        end
        if ((m == 4'h0) ? (tmr_r >= sqc_pkg::EMPTY_POS_CYC - sqc_pkg::ONE)
                        : ((m & below_down) == m)) begin
          state_nxt = sqc_pkg::S_DN_GAP;
          cas_oe_nxt = 1'b0;
          tmr_nxt = 32'h0000_0000;
        end
      end
      sqc_pkg::S_DN_GAP: begin
        tmr_nxt = tmr_r + sqc_pkg::ONE;
        if (tmr_r >= SPACING_CYCLES - sqc_pkg::ONE) begin
          tmr_nxt = 32'h0000_0000;
          if (pos_r == sqc_pkg::POS_FIRST) begin
            state_nxt = sqc_pkg::S_IDLE;
            done_oe_nxt = 1'b0;
          end else begin
            state_nxt = sqc_pkg::S_DN_POS;
            pos_nxt = pos_r - 4'h1;
            cas_oe_nxt = 1'b1;
          end
        end
      end
      sqc_pkg::S_FAULT: begin
        en_nxt = 4'h0;
        // no re-sequencing until the log is cleared
        if (!fault_any) begin
          state_nxt = sqc_pkg::S_IDLE;
        end
      end
      default: begin
        state_nxt = sqc_pkg::S_FAULT;
      end
    endcase
    if (seq_act && fault_any) begin
      state_nxt = sqc_pkg::S_FAULT;
      en_nxt = 4'h0;
      cas_oe_nxt = 1'b0;
      done_oe_nxt = 1'b0;
      pg_run_nxt = 1'b0;
    end
    if (seq_act) begin
      en_nxt = en_nxt & ~off_nxt;
    end
    rep_nxt = forcing ? sqc_pkg::sqc_fault_type'({2'h0, ext_fault}) : flog_nxt;
    flt_oe_nxt = forcing ? 1'b0 : ((flog_nxt.seq | flog_nxt.rst) != 1'b0);
    // pin is only sampled while released, so our own drive cannot be mistaken
    cap_nxt = 1'b1;
    last_nxt = (!cap_r && !done_oe_r) ? done_pin : last_r;
    thr_nxt = (!seq_threshold_strap_a && seq_threshold_strap_b) ? sqc_pkg::PCT_67
                                                                : sqc_pkg::PCT_100;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sqc_pkg::S_IDLE;
      pos_r <= sqc_pkg::POS_UNUSED;
      tmr_r <= 32'h0000_0000;
      pg_r <= 32'h0000_0000;
      pg_run_r <= 1'b0;
      done_oe_r <= 1'b0;
      cas_oe_r <= 1'b0;
      en_r <= 4'h0;
      cmp_r <= 4'h0;
      off_r <= 4'h0;
      flog_r <= '0;
      rep_r <= '0;
      flt_oe_r <= 1'b0;
      last_r <= 1'b0;
      cap_r <= 1'b0;
      thr_r <= sqc_pkg::PCT_100;
    end else begin
      state_r <= state_nxt;
      pos_r <= pos_nxt;
      tmr_r <= tmr_nxt;
      pg_r <= pg_nxt;
      pg_run_r <= pg_run_nxt;
      done_oe_r <= done_oe_nxt;
      cas_oe_r <= cas_oe_nxt;
      en_r <= en_nxt;
      cmp_r <= cmp_nxt;
      off_r <= off_nxt;
      flog_r <= flog_nxt;
      rep_r <= rep_nxt;
      flt_oe_r <= flt_oe_nxt;
      last_r <= last_nxt;
      cap_r <= cap_nxt;
      thr_r <= thr_nxt;
    end
  end

  // ****************************************
  // reset and overvoltage supervision
  // ****************************************
  always_comb begin
    rst_out_nxt = rst_out_r;
    rcnt_nxt = rcnt_r;
    ov_nxt = ov_r;
    ocnt_nxt = ocnt_r;
    if (!rst_ok) begin
      rst_out_nxt = 1'b0;
      rcnt_nxt = 32'h0000_0000;
    end else if (!rst_out_r) begin
      rcnt_nxt = rcnt_r + sqc_pkg::ONE;
      if (rcnt_r >= RESET_DELAY_CYCLES - sqc_pkg::ONE) begin
        rst_out_nxt = 1'b1;
      end
    end
    if (above_ov != 4'h0) begin
      ov_nxt = 1'b0;
      ocnt_nxt = 32'h0000_0000;
    end else if (!ov_r) begin
      ocnt_nxt = ocnt_r + sqc_pkg::ONE;
      if (ocnt_r >= RESET_DELAY_CYCLES - sqc_pkg::ONE) begin
        ov_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_out_r <= 1'b0;
      rcnt_r <= 32'h0000_0000;
      ov_r <= 1'b1;
      ocnt_r <= 32'h0000_0000;
    end else begin
      rst_out_r <= rst_out_nxt;
      rcnt_r <= rcnt_nxt;
      ov_r <= ov_nxt;
      ocnt_r <= ocnt_nxt;
    end
  end

  assign supply_enable = en_r;
  assign comparator_output = cmp_r;
  assign reset_out_n = rst_out_r;
  assign overvoltage_flag_n = ov_r;
  assign seq_threshold_pct = thr_r;
  assign last_status = last_r;
  assign fault_report = rep_r;
  assign fault_line_oe = flt_oe_r;
  assign done_pin_oe = done_oe_r;
  assign cas_pin_oe = cas_oe_r;
  // open-drain pins only ever drive low
  assign fault_line_o = 1'b0;
  assign done_pin_o = 1'b0;
  assign cas_pin_o = 1'b0;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  async_off_a: assert property (seq_act && (used != 4'hf) |=> (en_r & ~$past(used)) == 4'h0)
    else $error("unused channel enable not low");
  fault_shut_a: assert property (seq_act && fault_any |=> en_r == 4'h0)
    else $error("fault did not drop enables");
  force_en_a: assert property (!seq_act && !ext_fault && !seq_cmd |=> en_r == $past(forced))
    else $error("forced enables wrong");
  pct_sel_a: assert property (!seq_threshold_strap_a && seq_threshold_strap_b
                              |=> thr_r == sqc_pkg::PCT_67)
    else $error("threshold select wrong");
  rst_release_a: assert property ($rose(rst_out_r) |-> $past(rcnt_r) ==
                                  RESET_DELAY_CYCLES - sqc_pkg::ONE && $past(rst_ok))
    else $error("reset released early");
  ov_hold_a: assert property ((above_ov != 4'h0) |=> !ov_r ##1 !ov_r)
    else $error("overvoltage flag not held");
  fault_clear_a: assert property ((flog_r != 3'h0) && !clear && (ev == 3'h0)
                                  |=> flog_r == $past(flog_r))
    else $error("fault log cleared wrongly");
  spacing_a: assert property ($rose(cas_oe_r) && (state_r == sqc_pkg::S_UP_POS) &&
                              (pos_r != sqc_pkg::POS_FIRST)
                              |-> $past(tmr_r) == SPACING_CYCLES - sqc_pkg::ONE)
    else $error("enable spacing too short");
  done_up_a: assert property ($rose(done_oe_r) |-> $past(state_r) == sqc_pkg::S_UP_GAP &&
                              $past(pos_r) == sqc_pkg::POS_LAST)
    else $error("completion asserted early");
  suppress_a: assert property (forcing && !seq_cmd |=> !flog_r.seq && !flog_r.rst ||
                               $past(flog_r.seq || flog_r.rst))
    else $error("fault logged while forcing");
endmodule : sqc_channel_control
`default_nettype wire

// File: testbench/sqc_supply_model.sv
// behavioural model of four regulators and their monitor comparators
`default_nettype none
module sqc_supply_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] supply_enable,
  input wire logic [15:0] pos_cfg,
  input wire logic [3:0] ov_inject,
  input wire logic slow,
  output var sqc_pkg::sqc_chan_in_type [3:0] chans
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************
  // rail levels
  // ************************************
  // slow mode steps once in 32 cycles, so rails miss the power-good window
  logic [3:0] lvl_r [4];
  logic [4:0] div_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 5'h00;
      for (int i = 0; i < 4; i++) lvl_r[i] <= 4'h0;
    end else begin
      div_r <= div_r + 5'h01;
      for (int i = 0; i < 4; i++) begin
        if (!slow || div_r == 5'h00) begin
          if (supply_enable[i] && lvl_r[i] != 4'hf) lvl_r[i] <= lvl_r[i] + 4'h1;
          else if (!supply_enable[i] && lvl_r[i] != 4'h0) lvl_r[i] <= lvl_r[i] - 4'h1;
        end
      end
    end
  end
  // monitor i reads rail i only
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chans[i].pos = pos_cfg[4*i +: 4];
      chans[i].above_uv = lvl_r[i] >= 4'hc;
      chans[i].above_seq = lvl_r[i] >= 4'h8;
      chans[i].below_down = lvl_r[i] < 4'h4;
      chans[i].above_ov = ov_inject[i];
    end
  end
endmodule : sqc_supply_model
`default_nettype wire

// File: testbench/sqc_channel_control_tb.sv
// self-checking testbench for the supply sequencer channel control block
`default_nettype none
module sqc_channel_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] SP = 32'h0000_0014;
  localparam logic [31:0] PG = 32'h0000_00c8;
  localparam logic [31:0] RD = 32'h0000_001e;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic seq_cmd = 1'b0;
  logic sb = 1'b0;
  logic slow = 1'b0;
  logic [15:0] pos_cfg = 16'h2021;
  logic [3:0] ov_inject = 4'h0;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  sqc_pkg::sqc_chan_in_type [3:0] chans;
  sqc_pkg::sqc_fault_type fault_report;
  logic fault_line_oe, done_pin_oe, reset_out_n, overvoltage_flag_n, last_status, cas_pin_oe;
  logic [3:0] supply_enable;
  logic [3:0] comparator_output;
  logic [6:0] seq_threshold_pct;
  // board: flag tied to fault line, pull-up on completion pin
  wire logic fault_line_n = overvoltage_flag_n & ~fault_line_oe;
  wire logic done_pin = ~done_pin_oe;
  always #5 clock = ~clock;
  sqc_channel_control #(.SPACING_CYCLES(SP), .POWER_GOOD_CYCLES(PG),
    .RESET_DELAY_CYCLES(RD)) dut_u (.clock(clock), .rst_n(rst_n), .chans(chans),
    .seq_cmd(seq_cmd), .designation_strap_a(2'h0), .designation_strap_b(2'h0),
    .seq_threshold_strap_a(1'b0), .seq_threshold_strap_b(sb),
    .fault_line_n(fault_line_n), .fault_line_oe(fault_line_oe), .fault_line_o(),
    .done_pin(done_pin), .done_pin_oe(done_pin_oe), .done_pin_o(), .cas_pin_oe(cas_pin_oe),
    .cas_pin_o(), .supply_enable(supply_enable), .comparator_output(comparator_output),
    .reset_out_n(reset_out_n), .overvoltage_flag_n(overvoltage_flag_n),
    .seq_threshold_pct(seq_threshold_pct), .last_status(last_status),
    .fault_report(fault_report));
  sqc_supply_model model_u (.clock(clock), .rst_n(rst_n), .supply_enable(supply_enable),
    .pos_cfg(pos_cfg), .ov_inject(ov_inject), .slow(slow), .chans(chans));
  // ************************************
  // helpers
  // ************************************
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  // hang guard sized well above the whole run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      mismatches++;
      finish_test();
    end
  end
  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset;
    tick(2);
    check("rst", 32'(reset_out_n), 32'h0);
    check("ovf", 32'(overvoltage_flag_n), 32'h1);
    check("en", 32'(supply_enable), 32'h0);
    check("last", 32'(last_status), 32'h1);
    sb = 1'b1;
    tick(2);
    check("pct", 32'(seq_threshold_pct), 32'h43);
    sb = 1'b0;
    tick(2);
    check("pct", 32'(seq_threshold_pct), 32'h64);
    $display("test reset done");
  endtask : t_reset
  task automatic t_force;
    pos_cfg[3:0] = 4'hf;
    while (comparator_output[0] !== 1'b1) tick();
    check("en", 32'(supply_enable), 32'h1);
    check("cmp", 32'(comparator_output), 32'h1);
    check("flt", 32'(fault_report), 32'h0);
    pos_cfg[3:0] = 4'h1;
    while (chans[0].below_down !== 1'b1) tick();
    tick(2);
    check("en", 32'(supply_enable), 32'h0);
    $display("test force done");
  endtask : t_force
  task automatic t_up(input logic [3:0] exp);
    seq_cmd = 1'b1;
    while (supply_enable[0] !== 1'b1) tick();
    check("cas", 32'(cas_pin_oe), 32'h1);
    while (chans[0].above_seq !== 1'b1) tick();
    tick(2);
    check("cas", 32'(cas_pin_oe), 32'h0);
    n = 2;
    while (supply_enable[1] !== 1'b1) begin
      tick();
      n++;
    end
    check("gap", 32'(n > SP), 32'h1);
    while (done_pin_oe !== 1'b1) tick();
    check("en", 32'(supply_enable), 32'(exp));
    n = 0;
    while (reset_out_n !== 1'b1) begin
      tick();
      n++;
    end
    check("rdly", 32'(n >= RD && n <= RD + 2), 32'h1);
    check("cmp", 32'(comparator_output), 32'(exp));
    $display("test up done");
  endtask : t_up
  task automatic t_off;
    pos_cfg[15:12] = 4'h0;
    tick(2);
    check("en", 32'(supply_enable), 32'h3);
    pos_cfg[15:12] = 4'h2;
    tick(30);
    check("en", 32'(supply_enable), 32'h3);
    check("rst", 32'(reset_out_n), 32'h1);
    $display("test off done");
  endtask : t_off
  task automatic t_down;
    seq_cmd = 1'b0;
    tick(3);
    check("rst", 32'(reset_out_n), 32'h0);
    while (supply_enable[1] !== 1'b0) tick();
    check("order", 32'(supply_enable[0]), 32'h1);
    while (done_pin_oe !== 1'b0) tick();
    check("en", 32'(supply_enable), 32'h0);
    $display("test down done");
  endtask : t_down
  task automatic t_ov;
    ov_inject = 4'h1;
    tick(4);
    check("ovf", 32'(overvoltage_flag_n), 32'h0);
    check("en", 32'(supply_enable), 32'h0);
    check("ext", 32'(fault_report.ext), 32'h1);
    ov_inject = 4'h0;
    n = 0;
    while (overvoltage_flag_n !== 1'b1) begin
      tick();
      n++;
    end
    check("ovdly", 32'(n), RD);
    check("ext", 32'(fault_report.ext), 32'h1);
    seq_cmd = 1'b0;
    while (fault_report !== 3'h0) tick();
    check("clr", 32'(chans[0].below_down), 32'h1);
    $display("test overvoltage done");
  endtask : t_ov
  task automatic t_pg;
    slow = 1'b1;
    seq_cmd = 1'b1;
    while (supply_enable[0] !== 1'b1) tick();
    n = 0;
    while (fault_report.seq !== 1'b1) begin
      tick();
      n++;
    end
    check("pg", 32'(n >= PG - 1 && n <= PG + 2), 32'h1);
    tick(2);
    check("en", 32'(supply_enable), 32'h0);
    check("fltoe", 32'(fault_line_oe), 32'h1);
    seq_cmd = 1'b0;
    while (fault_report !== 3'h0) tick();
    check("fltoe", 32'(fault_line_oe), 32'h0);
    $display("test power good done");
  endtask : t_pg
  initial begin
    tick(3);
    rst_n = 1'b1;
    t_reset();
    t_force();
    t_up(4'hb);
    t_off();
    t_down();
    t_up(4'hb);
    t_ov();
    t_pg();
    finish_test();
  end
endmodule : sqc_channel_control_tb
`default_nettype wire
